// ### logic/ebus_arb_pkg.sv
// package for the external bus arbiter: carriers, states and constants
// assumes one bus clock; the external data bus is eight bits wide
package ebus_arb_pkg;

  localparam int ADDR_W     = 24;
  localparam int DATA_W     = 32;
  localparam int EXT_DATA_W = 8;
  localparam int IDLE_W     = 3;
  localparam int BEAT_W     = 2;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  localparam logic [BEAT_W-1:0] BEATS_BYTE = 2'h0;
  localparam logic [BEAT_W-1:0] BEATS_WORD = 2'h1;
  localparam logic [BEAT_W-1:0] BEATS_LONG = 2'h3;

  localparam logic             OWNER_CPU = 1'b0;
  localparam logic             OWNER_DTC = 1'b1;
  localparam logic             NEG_HIGH  = 1'b1;
  localparam logic [IDLE_W-1:0] IDLE_ZERO = 3'h0;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              test_and_set_instr;
    logic [1:0]        size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0]     addr;
    logic                  addr_oe_n;
    logic [EXT_DATA_W-1:0] data;
    logic                  data_oe_n;
    logic                  chip_select_n;
    logic                  rd_n;
    logic                  wr_n;
    logic                  ctrl_oe_n;
  } ext_bus_out_s;

  localparam ext_bus_out_s PINS_RESET = '{
    addr: 24'h00_0000, addr_oe_n: 1'b1, data: 8'h00, data_oe_n: 1'b1,
    chip_select_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ctrl_oe_n: 1'b1};

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_STROBE, ST_GAP,
    ST_REL_HIGH, ST_REL, ST_REL_WAIT, ST_RECLAIM
  } bus_state_e;

endpackage

// ### logic/external_bus_arbitration.sv
// external bus arbiter: grants cpu and transfer controller, hands the bus to an
// external master by request/acknowledge, and holds a one-entry write buffer.
// assumes requesters hold valid until their ack; all inputs synchronous.
`timescale 1ns/1ps
`default_nettype none

// Function
// - external request beats cpu beats controller
// - cpu never granted twice in a row while controller waits; code grants it twice across a test-and-set read/write
// - yield select lets unlocked controller beat cpu
// - no handover inside test-and-set read/write
// - split wide accesses finish before handover
// - controls negated before release and reclaim
// - release only at bus cycle boundary
// - idle gap cycles count as busy
// - request low: release, ack; high: resume
// - only external accesses stall while released
// - block low-power modes while released
// - tristate address/data, ack half cycle later
// - controls high one cycle, then tristate
// - sample external request on falling edge
// - reclaim: controls high 1.5 cycles, ack after; code drives controls high only half a cycle before ack
// - first cycle when address/data driven again
// - controller grant adds no dead cycle
// - power-on reset negates all, buffers off
// - manual reset finishes cycle, keeps settings
// - manual reset ignores external requests
// - one-entry write buffer; reads stall requester
module external_bus_arbitration
  import ebus_arb_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  manual_reset_i,
  input  wire logic                  ext_master_request_n_i,
  input  wire logic                  cpu_ext_yield_sel_i,
  input  wire logic                  xfer_lock_i,
  input  wire logic [IDLE_W-1:0]     idle_cycles_i,
  input  wire bus_req_s              cpu_req_i,
  input  wire bus_req_s              dtc_req_i,
  input  wire logic [EXT_DATA_W-1:0] ext_data_i,
  output ext_bus_out_s               ext_bus_o,
  output logic                       ext_master_ack_n_o,
  output logic                       cpu_ack_o,
  output logic [DATA_W-1:0]          cpu_rdata_o,
  output logic                       dtc_ack_o,
  output logic [DATA_W-1:0]          dtc_rdata_o,
  output logic                       standby_block_o
);

  function automatic logic [BEAT_W-1:0] beats_of(input logic [1:0] size);
    beats_of = (size == SIZE_BYTE) ? BEATS_BYTE :
               (size == SIZE_WORD) ? BEATS_WORD : BEATS_LONG;
  endfunction

  bus_state_e            state_q, state_d;
  bus_req_s              job_q, job_d;
  logic                  owner_q, owner_d;
  logic [BEAT_W-1:0]     left_q, left_d;
  logic [IDLE_W-1:0]     gap_q, gap_d;
  logic [DATA_W-1:0]     rsh_q;
  logic                  cpu_last_q;
  logic                  tas_lock_q;
  logic                  req_n_s_q;
  logic                  cpu_ack_q, dtc_ack_q;
  ext_bus_out_s          pins_q, pins_d;
  logic                  last_beat, finish_read, free, allow, ext_want;
  logic                  cpu_v, dtc_v, dtc_first, grant_cpu, grant_dtc;
  logic                  owned_d;

  assign last_beat   = (state_q == ST_STROBE) && (left_q == '0);
  assign finish_read = last_beat && !job_q.write;

  // a bus cycle boundary; gap cycles still count as busy
  assign free = (state_q == ST_IDLE) ||
                (last_beat && idle_cycles_i == IDLE_ZERO) ||
                ((state_q == ST_GAP) && gap_q == IDLE_ZERO);
  assign allow = free && !manual_reset_i;

  // requests whose answer is in flight are masked so they are not taken twice
  assign cpu_v = cpu_req_i.valid && !cpu_ack_q && !(finish_read && owner_q == OWNER_CPU);
  assign dtc_v = dtc_req_i.valid && !dtc_ack_q && !(finish_read && owner_q == OWNER_DTC)
                 && !tas_lock_q;

  // external master only outside manual reset and test-and-set
  assign ext_want  = !req_n_s_q && !manual_reset_i && !tas_lock_q;
  assign dtc_first = dtc_v && (cpu_last_q ||
                     (cpu_ext_yield_sel_i && !xfer_lock_i));

  always_comb begin
    grant_cpu = 1'b0;
    grant_dtc = 1'b0;
    if (allow && !ext_want) begin
      if (dtc_first) begin
        grant_dtc = 1'b1;
      end else if (cpu_v) begin
        grant_cpu = 1'b1;
      end else if (dtc_v) begin
        grant_dtc = 1'b1;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    job_d   = job_q;
    owner_d = owner_q;
    left_d  = left_q;
    gap_d   = gap_q;
    unique case (state_q)
      ST_IDLE, ST_GAP, ST_STROBE: begin
        if (state_q == ST_GAP && gap_q != IDLE_ZERO) begin
          gap_d = gap_q - 3'h1;
        end else if (state_q == ST_STROBE && left_q != '0) begin
          // next beat of a split access, no arbitration between beats
          state_d    = ST_ADDR;
          left_d     = left_q - 2'h1;
          job_d.addr = job_q.addr + 24'h00_0001;
          job_d.wdata = {job_q.wdata[DATA_W-EXT_DATA_W-1:0], 8'h00};
        end else if (state_q == ST_STROBE && idle_cycles_i != IDLE_ZERO) begin
          state_d = ST_GAP;
          gap_d   = idle_cycles_i - 3'h1;
        end else if (allow && ext_want) begin
          state_d = ST_REL_HIGH;
        end else if (grant_cpu || grant_dtc) begin
          // controller starts straight after the previous cycle
          state_d = ST_ADDR;
          job_d   = grant_dtc ? dtc_req_i : cpu_req_i;
          owner_d = grant_dtc ? OWNER_DTC : OWNER_CPU;
          left_d  = beats_of(job_d.size);
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_ADDR:     state_d = ST_STROBE;
      ST_REL_HIGH: state_d = ST_REL;
      ST_REL:      if (req_n_s_q) state_d = ST_REL_WAIT;
      ST_REL_WAIT: state_d = ST_RECLAIM;
      ST_RECLAIM:  state_d = ST_IDLE;
    endcase
  end

  // pins follow the next state so each one leaves a flip-flop
  always_comb begin
    owned_d = !(state_d == ST_REL || state_d == ST_REL_WAIT);
    pins_d  = PINS_RESET;
    pins_d.addr      = job_d.addr;
    pins_d.data      = job_d.wdata[DATA_W-1 -: EXT_DATA_W];
    // address/data float from release until the reclaim cycle ends
    pins_d.addr_oe_n = !(owned_d && state_d != ST_REL_HIGH && state_d != ST_RECLAIM);
    pins_d.data_oe_n = !((state_d == ST_ADDR || state_d == ST_STROBE) && job_d.write);
    // controls driven high around the handover, then floated
    pins_d.ctrl_oe_n     = !owned_d;
    pins_d.chip_select_n = !(state_d == ST_ADDR || state_d == ST_STROBE);
    pins_d.rd_n          = !(state_d == ST_STROBE && !job_d.write);
    pins_d.wr_n          = !(state_d == ST_STROBE && job_d.write);
  end

  // power-on reset floats every pin; manual reset touches nothing here
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      job_q   <= '0;
      owner_q <= OWNER_CPU;
      left_q  <= '0;
      gap_q   <= IDLE_ZERO;
      pins_q  <= PINS_RESET;
    end else begin
      state_q <= state_d;
      job_q   <= job_d;
      owner_q <= owner_d;
      left_q  <= left_d;
      gap_q   <= gap_d;
      pins_q  <= pins_d;
    end
  end

  // request sampled on the falling edge of the bus clock
  always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_n_s_q <= NEG_HIGH;
    end else begin
      req_n_s_q <= ext_master_request_n_i;
    end
  end

  // acknowledge moves half a cycle after the float or the drive-high
  always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_master_ack_n_o <= NEG_HIGH;
    end else if (state_q == ST_REL_HIGH) begin
      ext_master_ack_n_o <= 1'b0;
    end else if (state_q == ST_RECLAIM) begin
      ext_master_ack_n_o <= NEG_HIGH;
    end
  end

  // last granted master, for cpu/controller alternation
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_last_q <= 1'b0;
    end else if (grant_cpu || grant_dtc) begin
      cpu_last_q <= grant_cpu;
    end
  end

  // bus stays with the cpu from the test-and-set read to its write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tas_lock_q <= 1'b0;
    end else if (grant_cpu && cpu_req_i.test_and_set_instr && !cpu_req_i.write) begin
      tas_lock_q <= 1'b1;
    end else if (grant_cpu && cpu_req_i.write) begin
      tas_lock_q <= 1'b0;
    end
  end

  // read bytes collected high byte first
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsh_q <= '0;
    end else if (grant_cpu || grant_dtc) begin
      rsh_q <= '0;
    end else if (state_q == ST_STROBE) begin
      rsh_q <= {rsh_q[DATA_W-EXT_DATA_W-1:0], ext_data_i};
    end
  end

  // writes answered at grant (buffered), reads at their last beat
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_ack_q   <= 1'b0;
      dtc_ack_q   <= 1'b0;
      cpu_rdata_o <= '0;
      dtc_rdata_o <= '0;
    end else begin
      cpu_ack_q <= (grant_cpu && cpu_req_i.write) ||
                   (finish_read && owner_q == OWNER_CPU);
      dtc_ack_q <= (grant_dtc && dtc_req_i.write) ||
                   (finish_read && owner_q == OWNER_DTC);
      if (finish_read && owner_q == OWNER_CPU) begin
        cpu_rdata_o <= {rsh_q[DATA_W-EXT_DATA_W-1:0], ext_data_i};
      end
      if (finish_read && owner_q == OWNER_DTC) begin
        dtc_rdata_o <= {rsh_q[DATA_W-EXT_DATA_W-1:0], ext_data_i};
      end
    end
  end

  // low-power entry blocked while the bus is handed out
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      standby_block_o <= 1'b0;
    end else begin
      standby_block_o <= (state_d == ST_REL_HIGH) || (state_d == ST_REL) ||
                         (state_d == ST_REL_WAIT) || (state_d == ST_RECLAIM);
    end
  end

  assign ext_bus_o = pins_q;
  assign cpu_ack_o = cpu_ack_q;
  assign dtc_ack_o = dtc_ack_q;

endmodule

`default_nettype wire

// ### testbench/ebus_arb_checker.sv
// checker for the external bus arbiter: watches handover timing on the top ports
// assumes one bus clock; release steps land on rising and falling edges alike
`timescale 1ns/1ps
`default_nettype none
module ebus_arb_checker
  import ebus_arb_pkg::*;
(
  input wire logic         ref_clk_i,
  input wire logic         rst_n_i,
  input wire logic         manual_reset_i,
  input wire ext_bus_out_s ext_bus_o,
  input wire logic         ext_master_ack_n_o,
  input wire logic         cpu_ack_o,
  input wire logic         dtc_ack_o,
  input wire logic         standby_block_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic strobes_off = ext_bus_o.chip_select_n && ext_bus_o.rd_n && ext_bus_o.wr_n;

  property p_released; !ext_master_ack_n_o |-> ext_bus_o.addr_oe_n && ext_bus_o.data_oe_n;
  endproperty
  a_released: assert property (p_released) else $error("addr or data driven while released");
  property p_ctrl_neg; !ext_master_ack_n_o |-> strobes_off; endproperty
  a_ctrl_neg: assert property (p_ctrl_neg) else $error("strobe active while released");
  property p_ack_hold; $fell(ext_master_ack_n_o) |-> !ext_master_ack_n_o [*3]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge too short");
  property p_rel_high; $rose(ext_bus_o.ctrl_oe_n) |-> $past(strobes_off) && !ext_master_ack_n_o;
  endproperty
  a_rel_high: assert property (p_rel_high) else $error("controls not high before float");
  property p_reclaim; $fell(ext_bus_o.ctrl_oe_n) && !$past(ext_master_ack_n_o) |->
    ext_master_ack_n_o && ext_bus_o.chip_select_n && ext_bus_o.addr_oe_n; endproperty
  a_reclaim: assert property (p_reclaim) else $error("reclaim order wrong");
  property p_drive_after; $fell(ext_bus_o.addr_oe_n) |-> ext_master_ack_n_o
    && $past(ext_master_ack_n_o); endproperty
  a_drive_after: assert property (p_drive_after) else $error("address driven too early");
  property p_mrst; manual_reset_i && ext_master_ack_n_o |=> ext_master_ack_n_o; endproperty
  a_mrst: assert property (p_mrst) else $error("bus granted during manual reset");
  property p_standby; !ext_master_ack_n_o && !$past(ext_master_ack_n_o) |-> standby_block_o;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not blocked");
  property p_one_grant; !(cpu_ack_o && dtc_ack_o); endproperty
  a_one_grant: assert property (p_one_grant) else $error("two requesters granted");

  c_release: cover property ($fell(ext_master_ack_n_o));
  c_cpu: cover property (cpu_ack_o);
  c_dtc: cover property (dtc_ack_o);
endmodule
bind external_bus_arbitration ebus_arb_checker u_ebus_arb_checker (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .manual_reset_i(manual_reset_i), .ext_bus_o(ext_bus_o),
  .ext_master_ack_n_o(ext_master_ack_n_o), .cpu_ack_o(cpu_ack_o), .dtc_ack_o(dtc_ack_o),
  .standby_block_o(standby_block_o));
`default_nettype wire

// ### testbench/ext_master_model.sv
// far side of the bus: an external master that asks for the bus, plus read data made from the address xor a5
// assumes want_i changes off the rising edge; data toggles whenever no read strobe is low
`timescale 1ns/1ps
`default_nettype none
module ext_master_model
  import ebus_arb_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  want_i,
  input  wire logic                  ext_master_ack_n_i,
  input  wire ext_bus_out_s          ext_bus_i,
  output logic                       ext_master_request_n_o,
  output logic [EXT_DATA_W-1:0]      ext_data_o
);
  initial ext_master_request_n_o = 1'b1;
  initial ext_data_o = 8'h00;
  // a pending request stays low until acknowledged
  always @(posedge ref_clk_i) begin
    ext_master_request_n_o <= !(want_i || (!ext_master_request_n_o && ext_master_ack_n_i));
  end
  always @(negedge ref_clk_i) begin
    ext_data_o <= ext_bus_i.rd_n ? ~ext_data_o : ext_bus_i.addr[7:0] ^ 8'ha5;
  end
endmodule
`default_nettype wire

// ### testbench/tb_external_bus_arbitration.sv
// testbench for the external bus arbiter: requesters, external master and manual reset
// assumes inputs change on falling edges; the far side is ext_master_model
`timescale 1ns/1ps
`default_nettype none
module tb_external_bus_arbitration;
  import ebus_arb_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, mrst = 0, want = 0, ysel = 0, lock = 0;
  logic [IDLE_W-1:0] idle = IDLE_ZERO;
  bus_req_s cpu_q = '0, dtc_q = '0;
  ext_bus_out_s bus;
  logic ack_n, c_ack, d_ack, sb, req_n;
  logic [EXT_DATA_W-1:0] xd;
  logic [DATA_W-1:0] c_rd, d_rd;
  int num_errors = 0, total_checks = 0;
  always #4 ref_clk_i = ~ref_clk_i;

  external_bus_arbitration u_external_bus_arbitration (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .manual_reset_i(mrst), .ext_master_request_n_i(req_n),
    .cpu_ext_yield_sel_i(ysel), .xfer_lock_i(lock), .idle_cycles_i(idle), .cpu_req_i(cpu_q),
    .dtc_req_i(dtc_q), .ext_data_i(xd), .ext_bus_o(bus), .ext_master_ack_n_o(ack_n),
    .cpu_ack_o(c_ack), .cpu_rdata_o(c_rd), .dtc_ack_o(d_ack), .dtc_rdata_o(d_rd),
    .standby_block_o(sb));
  ext_master_model u_ext_master_model (.ref_clk_i(ref_clk_i), .want_i(want),
    .ext_master_ack_n_i(ack_n), .ext_bus_i(bus), .ext_master_request_n_o(req_n),
    .ext_data_o(xd));

  function automatic bus_req_s mk(logic w, logic [1:0] sz, logic [23:0] a, logic [31:0] d);
    return '{1'b1, w, 1'b0, sz, a, d};
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // waits at falling edges for a requester's ack, then drops its valid
  task automatic wait_ack(input logic transfer_controller, output int n);
    n = 0;
    while ((transfer_controller ? d_ack : c_ack) !== 1'b1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (transfer_controller) dtc_q.valid = 1'b0;
    else cpu_q.valid = 1'b0;
  endtask
  // ack_n moves on falling edges, so it is watched on rising edges
  task automatic wait_ackn(input logic v, output int n);
    n = 0;
    while (ack_n !== v && n < 40) begin
      @(posedge ref_clk_i);
      n++;
    end
    @(negedge ref_clk_i);
    chk("ack_n", {31'h0, v}, {31'h0, ack_n});
  endtask

  task automatic t_rw;
    int n;
    @(negedge ref_clk_i);
    cpu_q = mk(1'b1, SIZE_LONG, 24'h00_0010, 32'h1234_5678);
    wait_ack(1'b0, n);
    chk("buffered write wait", 1, n);
    @(negedge ref_clk_i);
    cpu_q = mk(1'b0, SIZE_LONG, 24'h00_0010, 32'h0000_0000);
    wait_ack(1'b0, n);
    chk("read after write wait", 15, n);
    chk("read data", 32'hb5b4_b7b6, c_rd);
    $display("done t_rw");
  endtask
  task automatic t_rel;
    int n;
    @(negedge ref_clk_i);
    cpu_q = mk(1'b0, SIZE_LONG, 24'h00_0020, 32'h0000_0000);
    want = 1'b1;
    wait_ack(1'b0, n);
    chk("split read wait", 9, n);
    chk("split read data", 32'h8584_8786, c_rd);
    wait_ackn(1'b0, n);
    chk("float to ack", 1, n);
    cpu_q = mk(1'b1, SIZE_BYTE, 24'h00_0030, 32'h0000_00aa);
    n = 0;
    repeat (6) begin
      @(negedge ref_clk_i);
      n += int'(c_ack === 1'b1);
    end
    chk("stall while released", 0, n);
    want = 1'b0;
    wait_ack(1'b0, n);
    chk("resume wait", 5, n);
    $display("done t_rel");
  endtask
  task automatic t_gap;
    int n;
    repeat (2) @(negedge ref_clk_i);
    idle = 3'h2;
    cpu_q = mk(1'b1, SIZE_BYTE, 24'h00_0080, 32'h0000_0055);
    wait_ack(1'b0, n);
    chk("gapped write wait", 1, n);
    want = 1'b1;
    wait_ackn(1'b0, n);
    chk("release after gap", 5, n);
    want = 1'b0;
    wait_ackn(1'b1, n);
    chk("reclaim to ack", 4, n);
    idle = IDLE_ZERO;
    $display("done t_gap");
  endtask
  task automatic t_prio;
    int n;
    @(negedge ref_clk_i);
    cpu_q = mk(1'b1, SIZE_LONG, 24'h00_0040, 32'h0102_0304);
    dtc_q = mk(1'b1, SIZE_BYTE, 24'h00_0050, 32'h0000_0011);
    wait_ack(1'b1, n);
    chk("controller after cpu", 1, n);
    wait_ack(1'b0, n);
    chk("cpu no dead cycle", 2, n);
    @(negedge ref_clk_i);
    cpu_q.valid = 1'b1;
    dtc_q.valid = 1'b1;
    wait_ack(1'b1, n);
    chk("controller between cpu", 7, n);
    @(negedge ref_clk_i);
    dtc_q.valid = 1'b1;
    wait_ack(1'b0, n);
    chk("cpu first", 1, n);
    wait_ack(1'b1, n);
    chk("no handover inside split", 8, n);
    repeat (10) @(negedge ref_clk_i);
    ysel = 1'b1;
    cpu_q = mk(1'b1, SIZE_BYTE, 24'h00_0060, 32'h0000_0022);
    dtc_q = mk(1'b1, SIZE_BYTE, 24'h00_0070, 32'h0000_0033);
    wait_ack(1'b1, n);
    chk("yield to controller", 1, n);
    wait_ack(1'b0, n);
    chk("cpu after controller", 2, n);
    @(negedge ref_clk_i);
    lock = 1'b1;
    dtc_q.valid = 1'b1;
    wait_ack(1'b1, n);
    @(negedge ref_clk_i);
    cpu_q.valid = 1'b1;
    dtc_q.valid = 1'b1;
    wait_ack(1'b0, n);
    chk("locked controller loses", 1, n);
    wait_ack(1'b1, n);
    chk("controller after locked cpu", 2, n);
    ysel = 1'b0;
    lock = 1'b0;
    $display("done t_prio");
  endtask
  task automatic t_mrst;
    int n;
    @(negedge ref_clk_i);
    cpu_q = mk(1'b0, SIZE_LONG, 24'h00_0020, 32'h0000_0000);
    @(negedge ref_clk_i);
    mrst = 1'b1;
    want = 1'b1;
    wait_ack(1'b0, n);
    chk("read ends in manual reset", 8, n);
    chk("manual reset read data", 32'h8584_8786, c_rd);
    repeat (20) @(negedge ref_clk_i);
    chk("no grant in manual reset", 1, {31'h0, ack_n});
    mrst = 1'b0;
    wait_ackn(1'b0, n);
    want = 1'b0;
    wait_ackn(1'b1, n);
    $display("done t_mrst");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (10) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_rw;
    t_rel;
    t_gap;
    t_prio;
    t_mrst;
    stop_test;
  end
endmodule
`default_nettype wire
